// *** core/sep_consts.svh ***
// sep_consts.svh: offsets, field positions and timing counts of the serial eeprom core.
// assumes: included by bare name from the package and the modules; definitions only.
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH
`define SEP_TYPE_MAIN 4'hA
`define SEP_TYPE_ID 4'hB
`define SEP_LOCK_ADR_BIT 2
`define SEP_LOCK_DATA_BIT 1
`define SEP_ID_BYTES 128
`define SEP_MEM_AW 16
`define SEP_PAGE_AW 7
`define SEP_TWR_MS 5
`define SEP_CLK_MHZ 200
`define SEP_TWR_CYC (`SEP_TWR_MS * `SEP_CLK_MHZ * 1000)
`define SEP_TMR_W 20
`define SEP_BIT_LAST 4'h8
`define SEP_IDLE_BYTE 8'hFF
`endif

// *** core/sep_pkg.sv ***
// sep_pkg: types shared by the serial eeprom core modules.
// assumes: sep_consts.svh is on the include path.
`include "sep_consts.svh"
package sep_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEVADR = 7'h02,
    ST_ADRHI = 7'h04,
    ST_ADRLO = 7'h08,
    ST_WDATA = 7'h10,
    ST_RDATA = 7'h20,
    ST_BUSY = 7'h40
  } sep_state_t;

  typedef struct packed {
    sep_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] tx;
    logic sda_oe;
    logic is_id;
    logic is_lock;
    logic lock_req;
    logic locked;
    logic wr_pend;
    logic rd;
    logic [7:0] ahi;
    logic [`SEP_MEM_AW-1:0] addr;
    logic [`SEP_MEM_AW-1:0] fptr;
    logic [`SEP_PAGE_AW-1:0] iptr;
    logic [`SEP_PAGE_AW-1:0] wptr;
    logic [`SEP_MEM_AW-`SEP_PAGE_AW-1:0] wpage;
    logic [`SEP_ID_BYTES-1:0] mask;
    logic [`SEP_TMR_W-1:0] timer;
  } sep_ctl_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } sep_det_t;

  typedef struct packed {
    logic [1:0][7:0] dat;
    logic [1:0] cnt;
  } sep_buf_t;
endpackage : sep_pkg

// *** core/sep_core_if.sv ***
// sep_core_if: bus events and the read-data stream inside the eeprom core.
// assumes: one clock; events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
interface sep_core_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic in_valid;
  logic in_ready;
  logic [7:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_data;
  logic flush;
  modport det (output scl_rise, output scl_fall, output start, output stop);
  modport buff (input in_valid, input in_data, input out_ready, input flush,
                output in_ready, output out_valid, output out_data);
  modport ctl (input scl_rise, input scl_fall, input start, input stop,
               input in_ready, input out_valid, input out_data,
               output in_valid, output in_data, output out_ready, output flush);
endinterface : sep_core_if
`default_nettype wire

// *** core/sep_cond_det.sv ***
// sep_cond_det: finds clock edges, start and stop on the two-wire bus.
// assumes: bus inputs are already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module sep_cond_det
  import sep_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  // events
  sep_core_if.det ev
);
  sep_det_t q;
  sep_det_t d;

  always_comb begin
    d.scl = scl_in;
    d.sda = sda_in;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q <= '1;
    end else begin
      q <= d;
    end
  end

  assign ev.scl_rise = scl_in & ~q.scl;
  assign ev.scl_fall = ~scl_in & q.scl;
  // data moving while clock stays high marks frame boundaries
  assign ev.start = scl_in & q.scl & q.sda & ~sda_in;
  assign ev.stop = scl_in & q.scl & ~q.sda & sda_in;
endmodule : sep_cond_det
`default_nettype wire

// *** core/sep_byte_buf.sv ***
// sep_byte_buf: two-entry byte buffer between the array fetch and the bit shifter.
// assumes: flush wins over push in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module sep_byte_buf
  import sep_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // stream
  sep_core_if.buff s
);
  sep_buf_t q;
  sep_buf_t d;
  logic push;
  logic pop;

  assign s.in_ready = (q.cnt != 2'h2);
  assign s.out_valid = (q.cnt != 2'h0);
  assign s.out_data = q.dat[0];

  always_comb begin
    d = q;
    push = s.in_valid & s.in_ready & ~s.flush;
    pop = s.out_ready & s.out_valid;
    if (s.flush) begin
      d.cnt = 2'h0;
    end else begin
      if (pop) begin
        d.dat[0] = q.dat[1];
      end
      if (push) begin
        d.dat[q.cnt - {1'b0, pop}] = s.in_data;
      end
      d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : sep_byte_buf
`default_nettype wire

// *** core/sep_eeprom_top.sv ***
// sep_eeprom_top: two-wire serial eeprom with read operations and a lockable id page.
// assumes: SCL and SDA are synchronous to CLK_IN and far slower than it; reset is power-on.
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_top
  import sep_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = `SEP_TWR_CYC
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // two-wire bus
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  // straps
  input wire logic [2:0] CHIP_SELECT_STRAPS_IN,
  input wire logic WRITE_INHIBIT_PIN_IN
);
  localparam int MEM_BYTES = 1 << `SEP_MEM_AW;

  sep_core_if ev ();

  sep_ctl_t q;
  sep_ctl_t d;

  logic [7:0] mem [MEM_BYTES];
  logic [7:0] id_mem [`SEP_ID_BYTES];
  logic [7:0] pbuf [`SEP_ID_BYTES];

  logic pbuf_we;
  logic cmt;
  logic [`SEP_PAGE_AW-1:0] cidx;
  logic match_main;
  logic match_id;
  logic pop;

  sep_cond_det u_det (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .scl_in(SCL_IN),
    .sda_in(SDA_IN),
    .ev(ev)
  );

  sep_byte_buf u_buf (
    .clk_in(CLK_IN),
    .reset_n_in(RESET_N_IN),
    .s(ev)
  );

  // device address decode
  assign match_main = (q.sh[7:4] == `SEP_TYPE_MAIN) && (q.sh[3:1] == CHIP_SELECT_STRAPS_IN);
  assign match_id = (q.sh[7:4] == `SEP_TYPE_ID) && (q.sh[3:1] == CHIP_SELECT_STRAPS_IN);

  // prefetch runs only while a read is open; in_ready stalls it when both entries are full
  assign ev.in_valid = q.rd;
  assign ev.in_data = q.is_id ? id_mem[q.fptr[`SEP_PAGE_AW-1:0]] : mem[q.fptr];
  assign ev.out_ready = pop;

  // commit walks the page buffer during the first cycles of the busy time
  assign cidx = q.timer[`SEP_PAGE_AW-1:0];
  assign cmt = (q.st == ST_BUSY) && (q.timer < `SEP_TMR_W'(`SEP_ID_BYTES)) && q.mask[cidx] && !q.is_lock;

  // open drain: only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE_OUT = q.sda_oe;

  always_comb begin
    d = q;
    pop = 1'b0;
    pbuf_we = 1'b0;
    ev.flush = 1'b0;
    if (ev.in_valid && ev.in_ready) begin
      d.fptr = q.fptr + `SEP_MEM_AW'(1);
    end
    if (q.st == ST_BUSY) begin
      // bus ignored entirely, no ack, until the cycle ends
      d.timer = q.timer + `SEP_TMR_W'(1);
      if (q.timer == '0 && q.is_lock && q.lock_req) begin
        d.locked = 1'b1;
      end
      if (q.timer == `SEP_TMR_W'(WRITE_CYCLES - 1)) begin
        d.st = ST_IDLE;
        d.timer = '0;
      end
    end else if (ev.start) begin
      d.st = ST_DEVADR;
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
      d.rd = 1'b0;
      // a repeated start drops a buffered write, so a random read never programs
      d.wr_pend = 1'b0;
      ev.flush = 1'b1;
    end else if (ev.stop) begin
      d.cnt = 4'h0;
      d.sda_oe = 1'b0;
      d.rd = 1'b0;
      d.wr_pend = 1'b0;
      // a pending write is dropped outright while the inhibit pin is high
      if (q.wr_pend && !WRITE_INHIBIT_PIN_IN) begin
        d.st = ST_BUSY;
        d.timer = '0;
      end else begin
        d.st = ST_IDLE;
      end
    end else if (ev.scl_fall) begin
      d.sda_oe = 1'b0;
      case (q.st)
        ST_RDATA: begin
          if (q.cnt != `SEP_BIT_LAST) begin
            d.sda_oe = ~q.tx[3'h7 - q.cnt[2:0]];
          end
        end
        ST_DEVADR: begin
          if (q.cnt == `SEP_BIT_LAST) begin
            if (match_main || match_id) begin
              d.sda_oe = 1'b1;
              d.is_id = match_id;
              if (q.sh[0]) begin
                // read: start fetching at the counter of the selected space
                d.fptr = match_id ? `SEP_MEM_AW'(q.iptr) : q.addr;
                d.rd = 1'b1;
                ev.flush = 1'b1;
              end
            end else begin
              d.st = ST_IDLE;
            end
          end
        end
        ST_ADRHI: begin
          if (q.cnt == `SEP_BIT_LAST) begin
            d.sda_oe = 1'b1;
            d.ahi = q.sh;
          end
        end
        ST_ADRLO: begin
          if (q.cnt == `SEP_BIT_LAST) begin
            d.sda_oe = 1'b1;
            d.wptr = q.sh[`SEP_PAGE_AW-1:0];
            d.mask = '0;
            d.lock_req = 1'b0;
            if (q.is_id) begin
              // upper bits ignored except the lock selector
              d.iptr = q.sh[`SEP_PAGE_AW-1:0];
              d.is_lock = q.ahi[`SEP_LOCK_ADR_BIT];
            end else begin
              d.addr = {q.ahi, q.sh};
              d.wpage = {q.ahi, q.sh[7]};
              d.is_lock = 1'b0;
            end
          end
        end
        ST_WDATA: begin
          if (q.cnt == `SEP_BIT_LAST) begin
            if (q.is_id && q.locked) begin
              d.sda_oe = 1'b0;
            end else if (q.is_lock) begin
              d.sda_oe = 1'b1;
              d.lock_req = q.sh[`SEP_LOCK_DATA_BIT];
              d.wr_pend = 1'b1;
            end else begin
              d.sda_oe = 1'b1;
              pbuf_we = 1'b1;
              d.mask[q.wptr] = 1'b1;
              d.wptr = q.wptr + `SEP_PAGE_AW'(1);
              d.wr_pend = 1'b1;
              if (q.is_id) begin
                d.iptr = q.wptr + `SEP_PAGE_AW'(1);
              end else begin
                d.addr = {q.wpage, q.wptr + `SEP_PAGE_AW'(1)};
              end
            end
          end
        end
        default: begin
          d.sda_oe = 1'b0;
        end
      endcase
    end else if (ev.scl_rise) begin
      case (q.st)
        ST_DEVADR, ST_ADRHI, ST_ADRLO, ST_WDATA: begin
          if (q.cnt != `SEP_BIT_LAST) begin
            d.sh = {q.sh[6:0], SDA_IN};
            d.cnt = q.cnt + 4'h1;
          end else begin
            d.cnt = 4'h0;
            case (q.st)
              ST_DEVADR: begin
                if (q.sh[0]) begin
                  d.st = ST_RDATA;
                  pop = 1'b1;
                  d.tx = ev.out_valid ? ev.out_data : `SEP_IDLE_BYTE;
                  if (q.is_id) begin
                    d.iptr = q.iptr + `SEP_PAGE_AW'(1);
                  end else begin
                    d.addr = q.addr + `SEP_MEM_AW'(1);
                  end
                end else begin
                  d.st = ST_ADRHI;
                end
              end
              ST_ADRHI: d.st = ST_ADRLO;
              ST_ADRLO: d.st = ST_WDATA;
              default: d.st = ST_WDATA;
            endcase
          end
        end
        ST_RDATA: begin
          if (q.cnt != `SEP_BIT_LAST) begin
            d.cnt = q.cnt + 4'h1;
          end else begin
            d.cnt = 4'h0;
            if (!SDA_IN) begin
              // master acked: next byte, counter wraps at the top of its space
              pop = 1'b1;
              d.tx = ev.out_valid ? ev.out_data : `SEP_IDLE_BYTE;
              if (q.is_id) begin
                d.iptr = q.iptr + `SEP_PAGE_AW'(1);
              end else begin
                d.addr = q.addr + `SEP_MEM_AW'(1);
              end
            end else begin
              d.st = ST_IDLE;
              d.rd = 1'b0;
            end
          end
        end
        default: begin
          d.cnt = q.cnt;
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      q <= '0;
      q.st <= ST_IDLE;
    end else begin
      q <= d;
    end
  end

  // storage arrays are not reset; they stand for nonvolatile cells
  always_ff @(posedge CLK_IN) begin
    if (pbuf_we) begin
      pbuf[q.wptr] <= q.sh;
    end
    if (cmt && q.is_id) begin
      id_mem[cidx] <= pbuf[cidx];
    end
    if (cmt && !q.is_id) begin
      mem[{q.wpage, cidx}] <= pbuf[cidx];
    end
  end
endmodule : sep_eeprom_top
`default_nettype wire

// *** dv/sep_eeprom_props.sv ***
// sep_eeprom_props: port-level checks of the serial eeprom core.
// assumes: bus phases span several CLK_IN cycles; bound onto sep_eeprom_top.
`timescale 1ns/1ps
`default_nettype none
module sep_eeprom_props #(
  parameter int unsigned BUSY_CYCLES = 200
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RESET_N_IN,
  // bus and straps
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic SDA_OE_OUT,
  input wire logic [2:0] CHIP_SELECT_STRAPS_IN,
  input wire logic WRITE_INHIBIT_PIN_IN
);
  logic scl_q;
  logic sda_q;
  logic rd_q;
  logic fb_q;
  logic [3:0] n_q;
  logic [7:0] sh_q;
  logic [1:0] bi_q;
  logic wd_q;
  int unsigned busy_q;
  wire logic rise = SCL_IN & ~scl_q;
  wire logic strt = SCL_IN & scl_q & sda_q & ~SDA_IN;
  wire logic stp = SCL_IN & scl_q & ~sda_q & SDA_IN;
  wire logic last = rise & (n_q == 4'h8);
  wire logic ours = (sh_q[7:5] == 3'b101) && (sh_q[3:1] == CHIP_SELECT_STRAPS_IN);
  // follows the frame from the wire so checks know which bit slot is on
  always_ff @(posedge CLK_IN) begin
    scl_q <= SCL_IN;
    sda_q <= SDA_IN;
    if (!RESET_N_IN || strt) begin
      n_q <= 4'h0;
      fb_q <= RESET_N_IN;
      bi_q <= 2'h0;
      wd_q <= 1'b0;
    end else if (rise) begin
      n_q <= (n_q == 4'h9) ? 4'h1 : n_q + 4'h1;
      if (n_q < 4'h8) sh_q <= {sh_q[6:0], SDA_IN};
      if (fb_q && n_q == 4'h7) rd_q <= SDA_IN;
      if (n_q == 4'h9) fb_q <= 1'b0;
      if (n_q == 4'h8 && bi_q != 2'h3) bi_q <= bi_q + 2'h1;
      // an acked data byte of a write frame arms the programming time
      if (n_q == 4'h8 && bi_q == 2'h3 && !rd_q && SDA_OE_OUT) wd_q <= 1'b1;
    end else if (stp) begin
      wd_q <= 1'b0;
    end
  end
  // programming time after a write stop, unless the inhibit pin drops it
  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      busy_q <= 0;
    end else if (stp && wd_q && !WRITE_INHIBIT_PIN_IN) begin
      busy_q <= BUSY_CYCLES;
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 1;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  chk_addr_quiet: assert property (rise && fb_q && n_q < 4'h8 |-> !SDA_OE_OUT)
    else $error("device drove address bit");
  chk_addr_ack: assert property (last && fb_q && ours && busy_q == 0 |-> SDA_OE_OUT)
    else $error("own address not acknowledged");
  chk_busy_quiet: assert property (last && busy_q != 0 |-> !SDA_OE_OUT)
    else $error("device answered while programming");
  chk_foreign_nack: assert property (last && fb_q && !ours |-> !SDA_OE_OUT)
    else $error("foreign address acknowledged");
  chk_master_slot: assert property (last && rd_q && !fb_q |-> !SDA_OE_OUT)
    else $error("device drove master ack slot");
  chk_nack_quiet: assert property (last && rd_q && !fb_q && SDA_IN |=> !SDA_OE_OUT [*8])
    else $error("device kept sending after no-ack");
  chk_oe_hold: assert property (SCL_IN && $past(SCL_IN) |-> $stable(SDA_OE_OUT))
    else $error("SDA changed while SCL high");
  chk_rise_low: assert property ($rose(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN))
    else $error("SDA pulled at wrong moment");
  chk_bit_width: assert property ($rose(SDA_OE_OUT) |-> SDA_OE_OUT [*6])
    else $error("driven bit too short");
  cov_nack_end: cover property (last && rd_q && !fb_q && SDA_IN);
  cov_foreign: cover property (last && fb_q && !SDA_OE_OUT);
  cov_refused: cover property (last && !fb_q && !rd_q && !SDA_OE_OUT);
  cov_busy_poll: cover property (last && fb_q && busy_q != 0);
endmodule : sep_eeprom_props
bind sep_eeprom_top sep_eeprom_props #(.BUSY_CYCLES(WRITE_CYCLES)) i_sep_eeprom_props (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SDA_OE_OUT(SDA_OE_OUT), .CHIP_SELECT_STRAPS_IN(CHIP_SELECT_STRAPS_IN),
  .WRITE_INHIBIT_PIN_IN(WRITE_INHIBIT_PIN_IN));
`default_nettype wire

// *** dv/sep_bus_master.sv ***
// sep_bus_master: behavioural two-wire bus master for the eeprom core.
// assumes: sda_in is the resolved wire with pull-up; tasks run from one process.
`timescale 1ns/1ps
`default_nettype none
module sep_bus_master (
  // clock
  input wire logic clk_in,
  // bus
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // sda_out high releases the line; scl stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : hold
  task automatic start();
    sda_out = 1'b1;
    hold(3);
    scl_out = 1'b1;
    hold(5);
    sda_out = 1'b0;
    hold(5);
    scl_out = 1'b0;
    hold(2);
  endtask : start
  task automatic stop();
    sda_out = 1'b0;
    hold(3);
    scl_out = 1'b1;
    hold(5);
    sda_out = 1'b1;
    hold(5);
  endtask : stop
  task automatic bitx(input logic b, output logic r);
    sda_out = b;
    hold(3);
    scl_out = 1'b1;
    hold(2);
    r = sda_in;
    hold(3);
    scl_out = 1'b0;
    hold(2);
  endtask : bitx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = ~r;
  endtask : wbyte
  // more low sends the closing no-acknowledge
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~more, r);
  endtask : rbyte
endmodule : sep_bus_master
`default_nettype wire

// *** dv/tb_top.sv ***
// tb_top: self-checking bench of the serial eeprom core against a byte model.
// assumes: WRITE_CYCLES is shortened; the bus master model paces every frame.
`timescale 1ns/1ps
`default_nettype none
`include "sep_consts.svh"
module tb_top;
  localparam int WC = 200;
  logic clk;
  logic rst_n;
  logic inh;
  logic scl;
  logic m_sda;
  logic sda_oe;
  logic sda_o;
  logic [2:0] cs;
  // open drain with pull-up: the device's driven level counts only while enabled
  wire logic sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
  int err_count = 0;
  int checks = 0;
  logic [31:0] rnd = 32'hA3B1;
  logic [7:0] mem [int];
  logic [7:0] idp [128];
  logic locked = 1'b0;
  logic [15:0] ctr = 16'h0000;
  sep_eeprom_top #(.WRITE_CYCLES(WC)) i_sep_eeprom_top (.CLK_IN(clk), .RESET_N_IN(rst_n), .SCL_IN(scl),
    .SDA_IN(sda_w), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .CHIP_SELECT_STRAPS_IN(cs), .WRITE_INHIBIT_PIN_IN(inh));
  sep_bus_master i_sep_bus_master (.clk_in(clk), .sda_in(sda_w), .scl_out(scl), .sda_out(m_sda));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  task automatic tally_and_finish();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // kind 0 main array, 1 id page, 2 lock command
  task automatic wr(input int k, input logic [15:0] a, input logic [7:0] d [$]);
    logic ack;
    if (k != 0) a[10] = (k == 2);
    i_sep_bus_master.start();
    i_sep_bus_master.wbyte({(k != 0) ? `SEP_TYPE_ID : `SEP_TYPE_MAIN, cs, 1'b0}, ack);
    cmp("dev ack", 8'h01, {7'h00, ack});
    i_sep_bus_master.wbyte(a[15:8], ack);
    i_sep_bus_master.wbyte(a[7:0], ack);
    foreach (d[i]) begin
      i_sep_bus_master.wbyte(d[i], ack);
      cmp("data ack", {7'h00, k != 1 || !locked}, {7'h00, ack});
      if (!inh && k == 0) mem[{a[15:7], a[6:0] + 7'(i)}] = d[i];
      if (!inh && k == 1 && !locked) idp[a[6:0] + 7'(i)] = d[i];
      if (!inh && k == 2 && d[i][1]) locked = 1'b1;
    end
    i_sep_bus_master.stop();
    i_sep_bus_master.hold(WC + 20);
  endtask : wr
  task automatic rd(input int k, input logic [15:0] a, input int n, input logic cur);
    logic ack;
    logic [7:0] g;
    logic [3:0] t;
    t = (k != 0) ? `SEP_TYPE_ID : `SEP_TYPE_MAIN;
    if (cur) a = ctr;
    if (!cur) begin
      i_sep_bus_master.start();
      i_sep_bus_master.wbyte({t, cs, 1'b0}, ack);
      i_sep_bus_master.wbyte(a[15:8], ack);
      i_sep_bus_master.wbyte(a[7:0], ack);
    end
    i_sep_bus_master.start();
    i_sep_bus_master.wbyte({t, cs, 1'b1}, ack);
    cmp("read dev ack", 8'h01, {7'h00, ack});
    for (int i = 0; i < n; i++) begin
      i_sep_bus_master.rbyte(i < n - 1, g);
      cmp("read byte", (k != 0) ? idp[a[6:0] + 7'(i)] : mem[a + 16'(i)], g);
    end
    i_sep_bus_master.stop();
    if (k == 0) ctr = a + 16'(n);
  endtask : rd
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // far above the roughly 13k cycles the sequence needs
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
  initial begin
    logic [15:0] a;
    logic ack;
    rst_n = 1'b0;
    inh = 1'b0;
    rnd = lfsr(rnd);
    cs = rnd[2:0];
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1'b1;
    i_sep_bus_master.hold(3);
    rnd = lfsr(rnd);
    a = rnd[15:0] & 16'hFFBF;
    wr(0, a, '{rnd[23:16], rnd[31:24], 8'h5A, 8'hC3});
    rd(0, a, 2, 1'b0);
    repeat (2) rd(0, a, 1, 1'b1);
    wr(0, 16'hFFFF, '{8'h11});
    wr(0, 16'h0000, '{8'h22});
    rd(0, 16'hFFFF, 2, 1'b0);
    for (int i = 0; i < 2; i++) begin
      i_sep_bus_master.start();
      i_sep_bus_master.wbyte((i != 0) ? {4'h5, cs, 1'b0} : {`SEP_TYPE_MAIN, ~cs, 1'b1}, ack);
      cmp("foreign ack", 8'h00, {7'h00, ack});
      i_sep_bus_master.stop();
    end
    // poll right after a write: the device stays off the bus while it programs
    i_sep_bus_master.start();
    i_sep_bus_master.wbyte({`SEP_TYPE_MAIN, cs, 1'b0}, ack);
    i_sep_bus_master.wbyte(8'h12, ack);
    i_sep_bus_master.wbyte(8'h34, ack);
    i_sep_bus_master.wbyte(rnd[7:0], ack);
    mem[16'h1234] = rnd[7:0];
    i_sep_bus_master.stop();
    i_sep_bus_master.start();
    i_sep_bus_master.wbyte({`SEP_TYPE_MAIN, cs, 1'b1}, ack);
    cmp("busy ack", 8'h00, {7'h00, ack});
    i_sep_bus_master.stop();
    i_sep_bus_master.hold(WC + 20);
    rd(0, 16'h1234, 1, 1'b0);
    rnd = lfsr(rnd);
    wr(1, {rnd[15:7], 7'h7E}, '{rnd[23:16], 8'h3C, rnd[31:24], 8'h81});
    rd(1, {rnd[31:23], 7'h7E}, 2, 1'b0);
    rd(1, {rnd[8:0], 7'h00}, 2, 1'b0);
    inh = 1'b1;
    wr(0, a, '{8'hEE});
    wr(1, 16'h0000, '{8'hEE});
    wr(2, rnd[15:0], '{8'hFF});
    inh = 1'b0;
    rd(0, a, 1, 1'b0);
    rd(1, 16'h0000, 2, 1'b0);
    wr(2, rnd[31:16], '{8'hFD});
    wr(1, 16'h0005, '{8'h77});
    wr(2, rnd[15:0], '{rnd[7:0] | 8'h02});
    wr(1, 16'h007E, '{8'h00, 8'h99});
    rd(1, 16'h007E, 2, 1'b0);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
